/* File: rtl/tci_map.vh */
// Purpose: Register map, field positions and codes of the timer interrupt block
// Assumes: 32-bit AXI4-Lite data, one register per aligned word
// Notes:   Definitions only
`ifndef TCI_MAP_VH
`define TCI_MAP_VH

// Register byte offsets
`define TCI_OFF_MASK      8'h00
`define TCI_OFF_FLAGS     8'h04
`define TCI_OFF_CLEAR     8'h08
`define TCI_OFF_CTRL      8'h0c
`define TCI_OFF_CAPT      8'h10

// Field positions
`define TCI_BIT_CAP       5
`define TCI_BIT_OVF       0
`define TCI_BIT_NOISE     7
`define TCI_BIT_EDGE      6
`define TCI_BIT_WGM       4

// Implemented bits per register
`define TCI_IRQ_BITS      8'h21
`define TCI_CTRL_BITS     8'hd0

// Reset values
`define TCI_RST_BYTE      8'h00
`define TCI_RST_WORD      16'h0000
`define TCI_RST_DATA      32'h0000_0000

// Bus answers
`define TCI_RESP_OKAY     2'h0
`define TCI_RESP_SLVERR   2'h2

// Noise filter sample count
`define TCI_FILT_LEN      4

`endif

/* File: rtl/tci_capture_edge.v */
// Purpose: Capture pin qualifier with optional noise filter and edge select
// Assumes: Pin already synchronous to clk_i
// Notes:   Event output is a one-cycle registered pulse
`timescale 1ns/10ps
`include "tci_map.vh"

module tci_capture_edge #(
	parameter FILT_LEN = `TCI_FILT_LEN
) (
	// Clock and reset
	input  wire clk_i,
	input  wire rst_i,
	// Pin and settings
	input  wire pin_i,
	input  wire filter_en_i,
	input  wire rising_i,
	input  wire enable_i,
	// Qualified event
	output reg  event_o
);

	reg  [FILT_LEN-1:0] hist_q;
	reg                 filt_q;
	reg                 prev_q;
	wire                level;
	wire                all_one;
	wire                all_zero;

	assign all_one  = &hist_q;
	assign all_zero = ~|hist_q;
	// Filter adds FILT_LEN cycles of delay, traded for glitch immunity
	assign level    = filter_en_i ? filt_q : hist_q[0];

	always @(posedge clk_i) begin
		if (rst_i) begin
			hist_q  <= {FILT_LEN{1'b0}};
			filt_q  <= 1'b0;
			prev_q  <= 1'b0;
			event_o <= 1'b0;
		end else begin
			hist_q <= {hist_q[FILT_LEN-2:0], pin_i};
			if (all_one)
				filt_q <= 1'b1;
			else if (all_zero)
				filt_q <= 1'b0;
			prev_q <= level;
			// Disabled input gives no event at all
			event_o <= enable_i & (rising_i ? (level & ~prev_q) : (~level & prev_q));
		end
	end

endmodule

/* File: rtl/tci_timer_irq.v */
// Purpose: Capture and overflow flags, masks and interrupt requests of a 16-bit timer
// Assumes: Counter datapath outside gives its value and a timer tick enable
// Notes:   Registers reached over AXI4-Lite, one write and one read at a time
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/10ps
`include "tci_map.vh"

// Contract
// - Capture request only with capture enable bit 5, global enable and capture flag.
// - Overflow request only with overflow enable bit 0, global enable and overflow flag.
// - Bits 7 and 6 of mask and flag registers read zero.
// - Capture flag bit 5 sets on a qualified capture pin event.
// - In capture-as-TOP mode the capture flag sets when the counter reaches TOP.
// - Capture flag clears when the capture vector executes.
// - Writing one to the capture flag bit clears it; software must write one.
// - Overflow flag bit 0 clears when the overflow vector executes.
// - Writing one to the overflow flag bit clears it.
// - Overflow flag sets in the tick where the counter wraps from max to zero.
// - In capture-as-TOP mode the capture pin is disconnected.
module tci_timer_irq #(
	parameter ADDR_W = 8,
	parameter CNT_W  = 16
) (
	// Clock and reset
	input  wire              clk_i,
	input  wire              rst_i,
	// AXI4-Lite write address
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	// AXI4-Lite read address
	input  wire [ADDR_W-1:0] s_axi_araddr,
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	// Counter datapath
	input  wire [CNT_W-1:0]  counter_value_i,
	input  wire              timer_tick_i,
	input  wire              capture_pin_i,
	// Processor interrupt logic
	input  wire              global_irq_enable_i,
	input  wire              capture_vector_ack_i,
	input  wire              overflow_vector_ack_i,
	output wire              capture_irq_o,
	output wire              overflow_irq_o,
	output wire              irq_o,
	// Datapath control
	output wire              waveform_mode_bit_o,
	output wire [CNT_W-1:0]  capture_register_o
);

	// Write channel holding registers
	reg              aw_hold_q;
	reg [ADDR_W-1:0] awaddr_q;
	reg              w_hold_q;
	reg [31:0]       wdata_q;
	reg [3:0]        wstrb_q;

	// Block state
	reg [7:0]        timer_irq_mask_q;
	reg              capture_flag_q;
	reg              overflow_flag_q;
	reg [7:0]        ctrl_q;
	reg [CNT_W-1:0]  capture_register_q;

	// Next values and decodes
	reg              capture_flag_d;
	reg              overflow_flag_d;
	reg [31:0]       rd_data;
	reg [1:0]        rd_resp;
	reg [1:0]        wr_resp;
	wire             do_write;
	wire             do_read;
	wire             wr_mask;
	wire             wr_flags;
	wire             wr_clear;
	wire             wr_ctrl;
	wire             wr_capt;
	wire [7:0]       clr_bits;
	wire [7:0]       timer_irq_flags;
	wire             capture_irq_enable;
	wire             overflow_irq_enable;
	wire             ctc_mode;
	wire             pin_event;
	wire             top_hit;
	wire             wrap_hit;
	wire             cap_set;
	wire             cap_clr;
	wire             ovf_set;
	wire             ovf_clr;

	// Bus handshakes
	assign s_axi_awready = ~aw_hold_q;
	assign s_axi_wready  = ~w_hold_q;
	assign s_axi_arready = ~s_axi_rvalid;
	// Write only once both halves are held and the last answer is gone
	assign do_write      = aw_hold_q & w_hold_q & ~s_axi_bvalid;
	assign do_read       = s_axi_arvalid & ~s_axi_rvalid;

	// Register selects, byte lane 0 carries every 8-bit register
	assign wr_mask  = do_write & (awaddr_q == `TCI_OFF_MASK) & wstrb_q[0];
	assign wr_flags = do_write & (awaddr_q == `TCI_OFF_FLAGS) & wstrb_q[0];
	assign wr_clear = do_write & (awaddr_q == `TCI_OFF_CLEAR) & wstrb_q[0];
	assign wr_ctrl  = do_write & (awaddr_q == `TCI_OFF_CTRL) & wstrb_q[0];
	assign wr_capt  = do_write & (awaddr_q == `TCI_OFF_CAPT);

	// Ones clear, zeros leave the flag alone
	assign clr_bits = (wr_flags | wr_clear) ? wdata_q[7:0] : `TCI_RST_BYTE;

	// Mode and enable fields
	assign capture_irq_enable  = timer_irq_mask_q[`TCI_BIT_CAP];
	assign overflow_irq_enable = timer_irq_mask_q[`TCI_BIT_OVF];
	assign ctc_mode            = ctrl_q[`TCI_BIT_WGM];
	assign waveform_mode_bit_o = ctc_mode;
	assign capture_register_o  = capture_register_q;

	// Flag register view, unused positions are zero
	assign timer_irq_flags = {2'b00, capture_flag_q, 4'b0000, overflow_flag_q};

	// Pin qualifier, disconnected while the capture register is TOP
	tci_capture_edge #(
		.FILT_LEN (`TCI_FILT_LEN)
	) u_capture_edge (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.pin_i       (capture_pin_i),
		.filter_en_i (ctrl_q[`TCI_BIT_NOISE]),
		.rising_i    (ctrl_q[`TCI_BIT_EDGE]),
		.enable_i    (~ctc_mode),
		.event_o     (pin_event)
	);

	// Counter events, qualified by the timer tick
	assign top_hit  = timer_tick_i & (counter_value_i == capture_register_q);
	assign wrap_hit = timer_tick_i & (counter_value_i == {CNT_W{1'b1}});

	// Capture flag source depends on mode
	assign cap_set = ctc_mode ? top_hit : pin_event;
	assign cap_clr = capture_vector_ack_i | clr_bits[`TCI_BIT_CAP];
	assign ovf_set = wrap_hit;
	assign ovf_clr = overflow_vector_ack_i | clr_bits[`TCI_BIT_OVF];

	// Set beats clear so a same-cycle event is never lost
	always @* begin
		capture_flag_d = capture_flag_q;
		if (cap_set)
			capture_flag_d = 1'b1;
		else if (cap_clr)
			capture_flag_d = 1'b0;
		overflow_flag_d = overflow_flag_q;
		if (ovf_set)
			overflow_flag_d = 1'b1;
		else if (ovf_clr)
			overflow_flag_d = 1'b0;
	end

	// Interrupt requests
	assign capture_irq_o  = global_irq_enable_i & capture_irq_enable & capture_flag_q;
	assign overflow_irq_o = global_irq_enable_i & overflow_irq_enable & overflow_flag_q;
	assign irq_o          = capture_irq_o | overflow_irq_o;

	// Write answer, unmapped offsets get a slave error
	always @* begin
		case (awaddr_q)
			`TCI_OFF_MASK:  wr_resp = `TCI_RESP_OKAY;
			`TCI_OFF_FLAGS: wr_resp = `TCI_RESP_OKAY;
			`TCI_OFF_CLEAR: wr_resp = `TCI_RESP_OKAY;
			`TCI_OFF_CTRL:  wr_resp = `TCI_RESP_OKAY;
			`TCI_OFF_CAPT:  wr_resp = `TCI_RESP_OKAY;
			default:        wr_resp = `TCI_RESP_SLVERR;
		endcase
	end

	// Read mux, clear register reads as zero
	always @* begin
		rd_data = `TCI_RST_DATA;
		rd_resp = `TCI_RESP_OKAY;
		case (s_axi_araddr)
			`TCI_OFF_MASK: begin
				rd_data[7:0] = timer_irq_mask_q & `TCI_IRQ_BITS;
			end
			`TCI_OFF_FLAGS: begin
				rd_data[7:0] = timer_irq_flags;
			end
			`TCI_OFF_CLEAR: begin
				rd_data = `TCI_RST_DATA;
			end
			`TCI_OFF_CTRL: begin
				rd_data[7:0] = ctrl_q;
			end
			`TCI_OFF_CAPT: begin
				rd_data[CNT_W-1:0] = capture_register_q;
			end
			default: begin
				rd_resp = `TCI_RESP_SLVERR;
			end
		endcase
	end

	// Write address and data capture, in either order
	always @(posedge clk_i) begin
		if (rst_i) begin
			aw_hold_q <= 1'b0;
			awaddr_q  <= {ADDR_W{1'b0}};
			w_hold_q  <= 1'b0;
			wdata_q   <= `TCI_RST_DATA;
			wstrb_q   <= 4'h0;
		end else begin
			if (s_axi_awvalid & ~aw_hold_q) begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end else if (do_write) begin
				aw_hold_q <= 1'b0;
			end
			if (s_axi_wvalid & ~w_hold_q) begin
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end else if (do_write) begin
				w_hold_q <= 1'b0;
			end
		end
	end

	// Write response
	always @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `TCI_RESP_OKAY;
		end else begin
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_resp;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read response, one cycle after the address is taken
	always @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= `TCI_RST_DATA;
			s_axi_rresp  <= `TCI_RESP_OKAY;
		end else begin
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_data;
				s_axi_rresp  <= rd_resp;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Mask and control registers
	always @(posedge clk_i) begin
		if (rst_i) begin
			timer_irq_mask_q <= `TCI_RST_BYTE;
			ctrl_q           <= `TCI_RST_BYTE;
		end else begin
			if (wr_mask)
				timer_irq_mask_q <= wdata_q[7:0] & `TCI_IRQ_BITS;
			if (wr_ctrl)
				ctrl_q <= wdata_q[7:0] & `TCI_CTRL_BITS;
		end
	end

	// Flags
	always @(posedge clk_i) begin
		if (rst_i) begin
			capture_flag_q  <= 1'b0;
			overflow_flag_q <= 1'b0;
		end else begin
			capture_flag_q  <= capture_flag_d;
			overflow_flag_q <= overflow_flag_d;
		end
	end

	// Capture register: pin capture wins over a software write in the same cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			capture_register_q <= `TCI_RST_WORD;
		end else if (pin_event) begin
			capture_register_q <= counter_value_i;
		end else if (wr_capt) begin
			if (wstrb_q[0])
				capture_register_q[7:0] <= wdata_q[7:0];
			if (wstrb_q[1])
				capture_register_q[CNT_W-1:8] <= wdata_q[CNT_W-1:8];
		end
	end

endmodule

/* File: test/tci_timer_irq_props.sv */
// Purpose: Port checker for the timer interrupt block
// Assumes: Bound to tci_timer_irq
// Notes:   Capture ack checked with ticks idle, match timing varies
`timescale 1ns/10ps
module tci_timer_irq_props #(
	parameter ADDR_W = 8
) (
	// Clock and reset
	input wire              clk_i,
	input wire              rst_i,
	// Bus
	input wire              s_axi_bvalid,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire              s_axi_arvalid,
	input wire              s_axi_arready,
	input wire [31:0]       s_axi_rdata,
	input wire              s_axi_rvalid,
	// Timer and processor
	input wire [15:0]       counter_value_i,
	input wire              timer_tick_i,
	input wire              global_irq_enable_i,
	input wire              capture_vector_ack_i,
	input wire              overflow_vector_ack_i,
	input wire              capture_irq_o,
	input wire              overflow_irq_o,
	input wire              irq_o,
	input wire              waveform_mode_bit_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire wrap = timer_tick_i && counter_value_i == 16'hffff;
	a_cap_gie: assert property (capture_irq_o |-> global_irq_enable_i)
		else $error("capture request without global enable");
	a_ovf_gie: assert property (overflow_irq_o |-> global_irq_enable_i)
		else $error("overflow request without global enable");
	a_irq_or: assert property (irq_o == (capture_irq_o | overflow_irq_o))
		else $error("irq is not the OR of requests");
	a_rd_resv: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr < 8
		|=> s_axi_rdata[7:6] == 2'b00) else $error("reserved bits read nonzero");
	a_cap_ack: assert property (capture_vector_ack_i && waveform_mode_bit_o
		&& !timer_tick_i && !$past(timer_tick_i) |=> !capture_irq_o)
		else $error("capture flag kept after vector");
	a_ovf_ack: assert property (overflow_vector_ack_i && !wrap |=> !overflow_irq_o)
		else $error("overflow flag kept after vector");
	a_ovf_wrap: assert property ($rose(overflow_irq_o) && $stable(global_irq_enable_i)
		|-> $past(wrap) || $rose(s_axi_bvalid)) else $error("overflow without wrap");
	a_rst_quiet: assert property (disable iff (1'b0) rst_i
		|=> !irq_o && !s_axi_bvalid && !s_axi_rvalid) else $error("busy after reset");
	cover property (capture_irq_o && waveform_mode_bit_o);
	cover property (capture_vector_ack_i);
	cover property (overflow_vector_ack_i);
endmodule

/* File: test/tci_dp_model.sv */
// Purpose: Counter datapath and processor vector acks
// Assumes: One tick per cycle while running
// Notes:   One vector at a time, capture first
`timescale 1ns/10ps
module tci_dp_model (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Bench control
	input  wire        run_i,
	input  wire        load_i,
	input  wire [15:0] load_val_i,
	input  wire        ack_en_i,
	// Block side
	input  wire        top_mode_i,
	input  wire [15:0] top_i,
	input  wire        cap_irq_i,
	input  wire        ovf_irq_i,
	output reg  [15:0] cnt_o,
	output wire        tick_o,
	output reg         cap_ack_o,
	output reg         ovf_ack_o
);
	assign tick_o = run_i;
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_o <= 16'h0000;
			cap_ack_o <= 1'b0;
			ovf_ack_o <= 1'b0;
		end else begin
			// A missed TOP runs on to MAX and wraps
			if (load_i)
				cnt_o <= load_val_i;
			else if (run_i)
				cnt_o <= (top_mode_i && cnt_o == top_i) ? 16'h0000 : cnt_o + 16'h0001;
			cap_ack_o <= ack_en_i && cap_irq_i && !cap_ack_o;
			ovf_ack_o <= ack_en_i && ovf_irq_i && !cap_irq_i && !ovf_ack_o;
		end
	end
endmodule

/* File: test/tb.sv */
// Purpose: Bench for tci_timer_irq
// Assumes: Model drives counter and vector acks
// Notes:   Seeded random counter and TOP values
`timescale 1ns/10ps
module tb;
	reg         clk_i = 1'b0;
	reg         rst_i = 1'b1;
	reg  [7:0]  aw = 8'h00, ar = 8'h00;
	reg         awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
	reg  [31:0] wd = 32'h0000_0000, d;
	reg         pin = 1'b0, gie = 1'b0, run = 1'b0, ld = 1'b0, acken = 1'b0;
	reg  [15:0] ldv = 16'h0000, top;
	reg  [1:0]  r;
	wire        awr, wr, bv, arr, rv, cirq, oirq, irq, wgm, tick, cack, oack;
	wire [1:0]  br, rr;
	wire [31:0] rd;
	wire [15:0] cnt, capr;
	integer     error_cnt = 0, checks_done = 0, cyc = 0, nca = 0, noa = 0, i;
	integer     seed = 32'h5c88;
	tci_timer_irq i_tci_timer_irq (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr(aw),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(brdy), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
		.counter_value_i(cnt), .timer_tick_i(tick), .capture_pin_i(pin),
		.global_irq_enable_i(gie), .capture_vector_ack_i(cack),
		.overflow_vector_ack_i(oack), .capture_irq_o(cirq), .overflow_irq_o(oirq),
		.irq_o(irq), .waveform_mode_bit_o(wgm), .capture_register_o(capr));
	tci_dp_model i_tci_dp_model (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .load_i(ld),
		.load_val_i(ldv), .ack_en_i(acken), .top_mode_i(wgm), .top_i(capr),
		.cap_irq_i(cirq), .ovf_irq_i(oirq), .cnt_o(cnt), .tick_o(tick),
		.cap_ack_o(cack), .ovf_ack_o(oack));
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc = cyc + 1;
		nca = nca + cack;
		noa = noa + oack;
		if (cyc == 20000) begin
			error_cnt = error_cnt + 1;
			close_out;
		end
	end
	task close_out; begin
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end endtask
	task chk_word(input [31:0] g, input [31:0] e); begin
		checks_done = checks_done + 1;
		if (g !== e) begin
			$display("BAD %0t word %h want %h", $time, g, e);
			error_cnt = error_cnt + 1;
		end
	end endtask
	task chk_bit(input g, input e); begin
		checks_done = checks_done + 1;
		if (g !== e) begin
			$display("BAD %0t bit %b want %b", $time, g, e);
			error_cnt = error_cnt + 1;
		end
	end endtask
	// Only word-aligned offsets up to the capture register are mapped
	function [1:0] exp_resp(input [7:0] a);
		exp_resp = (a <= 8'h10 && a[1:0] == 2'b00) ? 2'h0 : 2'h2;
	endfunction
	// Bready held from the start, so the answer is taken when seen
	task axw(input [7:0] a, input [31:0] v); begin
		@(posedge clk_i);
		aw <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		@(posedge clk_i);
		while (bv !== 1'b1) begin
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
			@(posedge clk_i);
		end
		brdy <= 1'b0;
		chk_word({30'd0, br}, {30'd0, exp_resp(a)});
	end endtask
	task rdchk(input [7:0] a, input [31:0] e, input [1:0] er); begin
		@(posedge clk_i);
		ar <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		@(posedge clk_i);
		while (rv !== 1'b1) begin
			if (arr) arv <= 1'b0;
			@(posedge clk_i);
		end
		d = rd;
		r = rr;
		arv <= 1'b0;
		rrdy <= 1'b0;
		chk_word(d, e);
		chk_word({30'd0, r}, {30'd0, er});
	end endtask
	task loadrun(input [15:0] v); begin
		ld <= 1'b1;
		ldv <= v;
		run <= 1'b0;
		@(posedge clk_i);
		ld <= 1'b0;
		run <= 1'b1;
	end endtask
	// Stops the counter on the wrap to zero
	task wcnt0; begin
		// The load is only visible after the next edge
		@(posedge clk_i);
		i = 0;
		while (cnt !== 16'h0000 && i < 300) begin
			@(posedge clk_i);
			i = i + 1;
		end
		run <= 1'b0;
	end endtask
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 20; i = i + 4)
			rdchk(i, 32'h0000_0000, 2'h0);
		rdchk(8'h20, 32'h0000_0000, 2'h2);
		axw(8'h00, 32'hffff_ffff);
		rdchk(8'h00, 32'h0000_0021, 2'h0);
		axw(8'h20, 32'h0000_0000);
		rdchk(8'h00, 32'h0000_0021, 2'h0);
		$display("test registers done");
		loadrun(16'hfff8 | ($random(seed) & 7));
		wcnt0;
		rdchk(8'h04, 32'h0000_0001, 2'h0);
		chk_bit(oirq, 1'b0);
		gie <= 1'b1;
		@(posedge clk_i);
		chk_bit(oirq, 1'b1);
		chk_bit(cirq, 1'b0);
		axw(8'h04, 32'h0000_0000);
		rdchk(8'h04, 32'h0000_0001, 2'h0);
		axw(8'h04, 32'h0000_0001);
		rdchk(8'h04, 32'h0000_0000, 2'h0);
		$display("test overflow done");
		axw(8'h0c, 32'h0000_0040);
		pin <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk_bit(cirq, 1'b1);
		chk_bit(irq, 1'b1);
		rdchk(8'h10, {16'h0000, cnt}, 2'h0);
		rdchk(8'h04, 32'h0000_0020, 2'h0);
		axw(8'h04, 32'h0000_0020);
		rdchk(8'h04, 32'h0000_0000, 2'h0);
		$display("test capture pin done");
		top = 16'h0040 + ($random(seed) & 16'h00ff);
		axw(8'h10, {16'h0000, top});
		axw(8'h0c, 32'h0000_0050);
		pin <= 1'b0;
		repeat (3) @(posedge clk_i);
		pin <= 1'b1;
		repeat (6) @(posedge clk_i);
		rdchk(8'h04, 32'h0000_0000, 2'h0);
		rdchk(8'h10, {16'h0000, top}, 2'h0);
		chk_bit(wgm, 1'b1);
		chk_word({16'h0000, capr}, {16'h0000, top});
		loadrun(top - 16'h0004);
		repeat (10) @(posedge clk_i);
		loadrun(16'hfffa);
		wcnt0;
		rdchk(8'h04, 32'h0000_0021, 2'h0);
		acken <= 1'b1;
		repeat (8) @(posedge clk_i);
		rdchk(8'h04, 32'h0000_0000, 2'h0);
		chk_word(nca, 1);
		chk_word(noa, 1);
		$display("test top and vectors done");
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk(8'h00, 32'h0000_0000, 2'h0);
		rdchk(8'h0c, 32'h0000_0000, 2'h0);
		rdchk(8'h10, 32'h0000_0000, 2'h0);
		$display("test reset done");
		close_out;
	end
endmodule
bind tci_timer_irq tci_timer_irq_props #(.ADDR_W(ADDR_W)) i_props (.*);
